// ==== legacy_reload_timers.sv ====
// Purpose: two legacy counter/timers, shared prescaler and a reload timer
// Assumes: one system clock, AXI4-Lite register access, async pins
// Notes: all state freezes while ce is low
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps

module legacy_reload_timers (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [timer_pkg::AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [timer_pkg::AXI_DW-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [timer_pkg::AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [timer_pkg::AXI_DW-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic timer_a_count_pin,
  input wire logic timer_b_count_pin,
  input wire logic timer_a_gate_input,
  input wire logic timer_b_gate_input,
  input wire logic ext_osc_clk,
  output logic timer_c_irq
);
  import timer_pkg::*;

  function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_LEGACY_CTRL, IDX_MODE, IDX_A_LOW, IDX_B_LOW, IDX_A_HIGH, IDX_B_HIGH,
      IDX_CLK_SEL, IDX_C_CTRL, IDX_C_RELOAD_LOW, IDX_C_RELOAD_HIGH,
      IDX_C_LOW, IDX_C_HIGH, IDX_MISC: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // {hit, index}; upper address bits must be zero
  function automatic logic [IDX_W:0] decode(input logic [AXI_AW-1:0] a);
    logic [IDX_W-1:0] idx;
    idx = a[IDX_LSB +: IDX_W];
    decode = {(a[AXI_AW-1:IDX_LSB+IDX_W] == '0) && is_mapped(idx), idx};
  endfunction

  function automatic logic [5:0] wrap_next(input logic [5:0] cnt, input logic [5:0] n);
    wrap_next = (cnt == n - 6'd1) ? 6'd0 : cnt + 6'd1;
  endfunction

  // one increment of a legacy timer: {overflow, high, low}
  function automatic logic [16:0] legacy_step(input legacy_mode_t mode,
                                              input logic [7:0] hi,
                                              input logic [7:0] lo);
    logic [13:0] c13;
    c13 = {1'b0, hi, lo[4:0]} + 14'd1;
    case (mode)
      MODE_13: legacy_step = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
      MODE_16: legacy_step = {1'b0, hi, lo} + 17'd1;
      MODE_RELOAD8: legacy_step = (lo == 8'hff) ? {1'b1, hi, hi}
                                                : {1'b0, hi, lo + 8'd1};
      MODE_SPLIT: legacy_step = {lo == 8'hff, hi, lo + 8'd1};
      default: legacy_step = {1'b0, hi, lo};
    endcase
  endfunction

  // register state
  mode_reg_t mode_r;
  clk_sel_t clk_sel_r;
  legacy_ctrl_t lctrl_r;
  c_ctrl_t cctrl_r;
  misc_t misc_r;
  logic [7:0] a_low_r, a_high_r, b_low_r, b_high_r;
  logic [7:0] c_low_r, c_high_r, c_rl_low_r, c_rl_high_r;

  // bus state
  logic [AXI_AW-1:0] aw_addr_r;
  logic [7:0] w_byte_r;
  logic w_lane_r;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [AXI_DW-1:0] rdata_r;
  logic irq_r;

  // ---------------- pin synchronisers ----------------
  pins_t pin_s1_r, pin_s2_r, pin_prev_r;
  pins_t pin_raw;
  assign pin_raw = '{ext_osc: ext_osc_clk, count_b: timer_b_count_pin,
                     count_a: timer_a_count_pin, gate_b: timer_b_gate_input,
                     gate_a: timer_a_gate_input};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_prev_r <= '0;
    end else if (ce) begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_prev_r <= pin_s2_r;
    end
  end

  logic fall_a, fall_b, ext_rise;
  assign fall_a = pin_prev_r.count_a & ~pin_s2_r.count_a;
  assign fall_b = pin_prev_r.count_b & ~pin_s2_r.count_b;
  assign ext_rise = pin_s2_r.ext_osc & ~pin_prev_r.ext_osc;

  // ---------------- timebases ----------------
  logic [5:0] div12_r, div4_r, div48_r;
  logic [2:0] ext_cnt_r;
  logic tick12, tick4, tick48, tick_ext8, ps_tick;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div12_r <= '0;
      div4_r <= '0;
      div48_r <= '0;
      ext_cnt_r <= '0;
    end else if (ce) begin
      div12_r <= wrap_next(div12_r, DIV12);
      div4_r <= wrap_next(div4_r, DIV4);
      div48_r <= wrap_next(div48_r, DIV48);
      if (ext_rise) begin
        ext_cnt_r <= ext_cnt_r + 3'd1;
      end
    end
  end

  assign tick12 = div12_r == DIV12 - 6'd1;
  assign tick4 = div4_r == DIV4 - 6'd1;
  assign tick48 = div48_r == DIV48 - 6'd1;
  // counted on synchronised edges only, so the oscillator never clocks logic
  assign tick_ext8 = ext_rise && (ext_cnt_r == EXT_DIV_LAST);

  always_comb begin
    case (clk_sel_r.shared_prescale_field)
      PS_DIV12: ps_tick = tick12;
      PS_DIV4: ps_tick = tick4;
      PS_DIV48: ps_tick = tick48;
      PS_EXT8: ps_tick = tick_ext8;
      default: ps_tick = 1'b0;
    endcase
  end

  // ---------------- legacy timer control ----------------
  logic a_split, gate_a_on, gate_b_on;
  logic a_timer_tick, b_timer_tick, a_inc, a_hi_inc, b_inc;
  logic [16:0] a_step, b_step;
  logic a_ovf, a_hi_ovf, b_ovf;

  assign a_split = mode_r.timer_a_mode_field == MODE_SPLIT;
  assign gate_a_on = misc_r.gate_a_polarity ? pin_s2_r.gate_a : ~pin_s2_r.gate_a;
  assign gate_b_on = misc_r.gate_b_polarity ? pin_s2_r.gate_b : ~pin_s2_r.gate_b;
  assign a_timer_tick = clk_sel_r.timer_a_clock_select | ps_tick;
  assign b_timer_tick = clk_sel_r.timer_b_clock_select | ps_tick;

  assign a_inc = (mode_r.timer_a_counter_select ? fall_a : a_timer_tick)
                 & lctrl_r.timer_a_run
                 & (~mode_r.timer_a_gate_enable | gate_a_on);
  assign a_hi_inc = a_split & lctrl_r.timer_b_run & a_timer_tick;

  // with timer A split, timer B runs by mode alone and has no pin or flag
  assign b_inc = (mode_r.timer_b_mode_field != MODE_SPLIT)
                 & ((mode_r.timer_b_counter_select && !a_split) ? fall_b
                                                                : b_timer_tick)
                 & (a_split | (lctrl_r.timer_b_run
                               & (~mode_r.timer_b_gate_enable | gate_b_on)));

  assign a_step = legacy_step(mode_r.timer_a_mode_field, a_high_r, a_low_r);
  assign b_step = legacy_step(mode_r.timer_b_mode_field, b_high_r, b_low_r);
  assign a_ovf = a_inc & a_step[16];
  assign a_hi_ovf = a_hi_inc & (a_high_r == 8'hff);
  assign b_ovf = b_inc & b_step[16] & ~a_split;

  // ---------------- timer C control ----------------
  logic c_split, c_ext_tick, c_lo_tick, c_hi_tick;
  logic c_inc16, c_lo_inc, c_hi_inc, c_lo_wrap, c_full_wrap, c_hi_wrap;

  assign c_split = cctrl_r.timer_c_split_mode;
  assign c_ext_tick = cctrl_r.timer_c_external_select ? tick_ext8 : tick12;
  assign c_lo_tick = clk_sel_r.timer_c_low_clock_select | c_ext_tick;
  assign c_hi_tick = clk_sel_r.timer_c_high_clock_select | c_ext_tick;
  assign c_inc16 = ~c_split & cctrl_r.timer_c_run & c_lo_tick;
  assign c_lo_inc = c_split & c_lo_tick;
  assign c_hi_inc = c_split & cctrl_r.timer_c_run & c_hi_tick;
  assign c_lo_wrap = (c_inc16 | c_lo_inc) & (c_low_r == 8'hff);
  assign c_full_wrap = c_inc16 & ({c_high_r, c_low_r} == 16'hffff);
  assign c_hi_wrap = c_hi_inc & (c_high_r == 8'hff);

  // ---------------- register bus ----------------
  logic [IDX_W:0] aw_dec, ar_dec;
  logic wr_go;
  logic [7:0] wr_idx;
  logic [7:0] rd_byte;

  assign aw_dec = decode(aw_addr_r);
  assign ar_dec = decode(araddr);
  assign wr_go = ce & ~awready_r & ~wready_r & ~bvalid_r & aw_dec[IDX_W] & w_lane_r;
  assign wr_idx = aw_dec[IDX_W-1:0];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      aw_addr_r <= '0;
      w_byte_r <= REG_RST;
      w_lane_r <= 1'b0;
    end else if (ce) begin
      if (awvalid && awready_r) begin
        aw_addr_r <= awaddr;
        awready_r <= 1'b0;
      end
      if (wvalid && wready_r) begin
        w_byte_r <= wdata[7:0];
        w_lane_r <= wstrb[0];
        wready_r <= 1'b0;
      end
      if (!awready_r && !wready_r && !bvalid_r) begin
        bvalid_r <= 1'b1;
        bresp_r <= aw_dec[IDX_W] ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  always_comb begin
    case (ar_dec[IDX_W-1:0])
      IDX_LEGACY_CTRL: rd_byte = {lctrl_r[7:4], 4'h0};
      IDX_MODE: rd_byte = mode_r;
      IDX_A_LOW: rd_byte = a_low_r;
      IDX_B_LOW: rd_byte = b_low_r;
      IDX_A_HIGH: rd_byte = a_high_r;
      IDX_B_HIGH: rd_byte = b_high_r;
      IDX_CLK_SEL: rd_byte = clk_sel_r;
      IDX_C_CTRL: rd_byte = cctrl_r;
      IDX_C_RELOAD_LOW: rd_byte = c_rl_low_r;
      IDX_C_RELOAD_HIGH: rd_byte = c_rl_high_r;
      IDX_C_LOW: rd_byte = c_low_r;
      IDX_C_HIGH: rd_byte = c_high_r;
      IDX_MISC: rd_byte = {5'h00, misc_r[2:0]};
      default: rd_byte = REG_RST;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready_r) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= {24'h00_0000, ar_dec[IDX_W] ? rd_byte : REG_RST};
        rresp_r <= ar_dec[IDX_W] ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && rready) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // ---------------- configuration registers ----------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_r <= REG_RST;
      clk_sel_r <= REG_RST;
      misc_r <= REG_RST;
      c_rl_low_r <= REG_RST;
      c_rl_high_r <= REG_RST;
      {lctrl_r.timer_b_run, lctrl_r.timer_a_run} <= 2'b00;
      {cctrl_r.timer_c_low_irq_enable, cctrl_r.timer_c_split_mode} <= 2'b00;
      {cctrl_r.timer_c_run, cctrl_r.timer_c_external_select} <= 2'b00;
      // spare bits stay zero; only reset ever writes them
      lctrl_r.unused <= 4'h0;
      {cctrl_r.unused_hi, cctrl_r.unused_lo} <= 2'b00;
    end else if (wr_go) begin
      case (wr_idx)
        IDX_MODE: mode_r <= w_byte_r;
        IDX_CLK_SEL: clk_sel_r <= w_byte_r;
        IDX_MISC: misc_r <= {5'h00, w_byte_r[2:0]};
        IDX_C_RELOAD_LOW: c_rl_low_r <= w_byte_r;
        IDX_C_RELOAD_HIGH: c_rl_high_r <= w_byte_r;
        IDX_LEGACY_CTRL: {lctrl_r.timer_b_run, lctrl_r.timer_a_run}
                           <= {w_byte_r[6], w_byte_r[4]};
        IDX_C_CTRL: begin
          cctrl_r.timer_c_low_irq_enable <= w_byte_r[5];
          cctrl_r.timer_c_split_mode <= w_byte_r[3];
          cctrl_r.timer_c_run <= w_byte_r[2];
          cctrl_r.timer_c_external_select <= w_byte_r[0];
        end
        default: ;
      endcase
    end
  end

  // ---------------- overflow flags ----------------
  // a hardware set in the same cycle as a software clear wins
  logic wr_lctrl, wr_cctrl;
  assign wr_lctrl = wr_go && (wr_idx == IDX_LEGACY_CTRL);
  assign wr_cctrl = wr_go && (wr_idx == IDX_C_CTRL);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lctrl_r.timer_a_overflow_flag <= 1'b0;
      lctrl_r.timer_b_overflow_flag <= 1'b0;
    end else if (ce) begin
      lctrl_r.timer_a_overflow_flag <= a_ovf
          | (wr_lctrl ? w_byte_r[5] : lctrl_r.timer_a_overflow_flag);
      lctrl_r.timer_b_overflow_flag <= b_ovf | a_hi_ovf
          | (wr_lctrl ? w_byte_r[7] : lctrl_r.timer_b_overflow_flag);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cctrl_r.timer_c_high_overflow_flag <= 1'b0;
      cctrl_r.timer_c_low_overflow_flag <= 1'b0;
    end else if (ce) begin
      // only software clears these, never interrupt service
      cctrl_r.timer_c_high_overflow_flag <= c_full_wrap | c_hi_wrap
          | (wr_cctrl ? w_byte_r[7] : cctrl_r.timer_c_high_overflow_flag);
      cctrl_r.timer_c_low_overflow_flag <= c_lo_wrap
          | (wr_cctrl ? w_byte_r[6] : cctrl_r.timer_c_low_overflow_flag);
    end
  end

  // ---------------- legacy counters ----------------
  // a software write to a count byte beats the increment in that cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      a_low_r <= REG_RST;
      a_high_r <= REG_RST;
    end else if (ce) begin
      if (wr_go && wr_idx == IDX_A_LOW) begin
        a_low_r <= w_byte_r;
      end else if (a_inc) begin
        a_low_r <= a_step[7:0];
      end
      if (wr_go && wr_idx == IDX_A_HIGH) begin
        a_high_r <= w_byte_r;
      end else if (a_hi_inc) begin
        a_high_r <= a_high_r + 8'd1;
      end else if (a_inc && !a_split) begin
        a_high_r <= a_step[15:8];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      b_low_r <= REG_RST;
      b_high_r <= REG_RST;
    end else if (ce) begin
      if (wr_go && wr_idx == IDX_B_LOW) begin
        b_low_r <= w_byte_r;
      end else if (b_inc) begin
        b_low_r <= b_step[7:0];
      end
      if (wr_go && wr_idx == IDX_B_HIGH) begin
        b_high_r <= w_byte_r;
      end else if (b_inc) begin
        b_high_r <= b_step[15:8];
      end
    end
  end

  // ---------------- timer C counter ----------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      c_low_r <= REG_RST;
      c_high_r <= REG_RST;
    end else if (ce) begin
      if (wr_go && wr_idx == IDX_C_LOW) begin
        c_low_r <= w_byte_r;
      end else if (c_full_wrap || (c_lo_inc && c_lo_wrap)) begin
        c_low_r <= c_rl_low_r;
      end else if (c_inc16 || c_lo_inc) begin
        c_low_r <= c_low_r + 8'd1;
      end
      if (wr_go && wr_idx == IDX_C_HIGH) begin
        c_high_r <= w_byte_r;
      end else if (c_full_wrap || c_hi_wrap) begin
        c_high_r <= c_rl_high_r;
      end else if (c_hi_inc || (c_inc16 && c_lo_wrap)) begin
        c_high_r <= c_high_r + 8'd1;
      end
    end
  end

  // ---------------- interrupt request ----------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else if (ce) begin
      irq_r <= misc_r.timer_c_irq_enable
               & (cctrl_r.timer_c_high_overflow_flag
                  | (cctrl_r.timer_c_low_irq_enable
                     & cctrl_r.timer_c_low_overflow_flag));
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign timer_c_irq = irq_r;

endmodule

// ==== legacy_reload_timers_tb.sv ====
// Purpose: self-checking bench for the legacy and reload timer unit
// Assumes: registers reached over AXI4-Lite, one byte per word
// Notes: pin pulses and short waits keep every expected count exact
`timescale 1ns/1ps
module legacy_reload_timers_tb;
  import timer_pkg::*;
  logic sys_clk = 0;
  logic rst = 1;
  logic ce = 1;
  logic [AXI_AW-1:0] awaddr = '0;
  logic awvalid = 0;
  logic awready;
  logic [AXI_DW-1:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 0;
  logic [AXI_AW-1:0] araddr = '0;
  logic arvalid = 0;
  logic arready;
  logic [AXI_DW-1:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 0;
  logic timer_a_count_pin;
  logic timer_b_count_pin;
  logic timer_a_gate_input;
  logic timer_b_gate_input;
  logic ext_osc_clk;
  logic timer_c_irq;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  legacy_reload_timers legacy_reload_timers_i (.*);
  pin_partner pin_partner_i (.*);
  always #2.5 sys_clk = ~sys_clk;
  task automatic stop_test();
    $display("compares %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = 2'b00);
    @(posedge sys_clk);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= AXI_DW'(d);
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    chk(32'(bresp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = 2'b00);
    @(posedge sys_clk);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
    chk(rdata, AXI_DW'(d));
    chk(32'(rresp), 32'(er));
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 0;
    for (logic [7:0] i = 8'h89; i <= 8'h8e; i++) begin
      rd(i, 8'h00);
    end
    wr(IDX_MODE, 8'ha5);
    rd(IDX_MODE, 8'ha5);
    wr(8'h00, 8'h5a, RESP_SLVERR);
    rd(8'h00, 8'h00, RESP_SLVERR);
    wr(IDX_MODE, 8'h75);
    wr(IDX_LEGACY_CTRL, 8'h50);
    pin_partner_i.pulse(0, 5);
    pin_partner_i.pulse(1, 3);
    rd(IDX_A_LOW, 8'h05);
    rd(IDX_B_LOW, 8'h00);
    wr(IDX_MISC, 8'h01);
    wr(IDX_MODE, 8'h7d);
    pin_partner_i.pulse(0, 3);
    rd(IDX_A_LOW, 8'h05);
    pin_partner_i.gate(1, 0);
    pin_partner_i.pulse(0, 2);
    rd(IDX_A_LOW, 8'h07);
    // stop first, else the preset wraps before the run write and its flag is lost
    wr(IDX_MODE, 8'h70);
    wr(IDX_LEGACY_CTRL, 8'h00);
    wr(IDX_CLK_SEL, 8'h04);
    wr(IDX_A_HIGH, 8'hff);
    wr(IDX_A_LOW, 8'h1f);
    wr(IDX_LEGACY_CTRL, 8'h10);
    rd(IDX_LEGACY_CTRL, 8'h30);
    rd(IDX_A_HIGH, 8'h00);
    wr(IDX_C_RELOAD_LOW, 8'h34);
    wr(IDX_C_RELOAD_HIGH, 8'h12);
    wr(IDX_C_LOW, 8'hf0);
    wr(IDX_C_HIGH, 8'hff);
    wr(IDX_CLK_SEL, 8'h10);
    wr(IDX_MISC, 8'h04);
    wr(IDX_C_CTRL, 8'h04);
    repeat (40) @(posedge sys_clk);
    rd(IDX_C_HIGH, 8'h12);
    rd(IDX_C_CTRL, 8'hc4);
    chk(32'(timer_c_irq), 32'h1);
    wr(IDX_C_CTRL, 8'h04);
    rd(IDX_C_CTRL, 8'h04);
    chk(32'(timer_c_irq), 32'h0);
    wr(IDX_C_CTRL, 8'h24);
    repeat (250) @(posedge sys_clk);
    rd(IDX_C_CTRL, 8'h64);
    chk(32'(timer_c_irq), 32'h1);
    wr(IDX_C_CTRL, 8'h08);
    wr(IDX_C_HIGH, 8'h55);
    wr(IDX_C_LOW, 8'hf0);
    repeat (30) @(posedge sys_clk);
    rd(IDX_C_CTRL, 8'h48);
    rd(IDX_C_HIGH, 8'h55);
    chk(32'(timer_c_irq), 32'h0);
    // second of three pin edges reloads from the untouched high byte
    wr(IDX_LEGACY_CTRL, 8'h00);
    wr(IDX_MODE, 8'h76);
    wr(IDX_A_HIGH, 8'hfe);
    wr(IDX_A_LOW, 8'hfe);
    wr(IDX_LEGACY_CTRL, 8'h10);
    pin_partner_i.pulse(0, 3);
    rd(IDX_A_LOW, 8'hff);
    rd(IDX_A_HIGH, 8'hfe);
    rd(IDX_LEGACY_CTRL, 8'h30);
    // pin edges while frozen must not count once ce returns
    @(posedge sys_clk);
    ce <= 0;
    pin_partner_i.pulse(0, 2);
    ce <= 1;
    rd(IDX_A_LOW, 8'hff);
    // both high bytes on external /8: at least two ticks in 60 cycles, so one wrap each
    wr(IDX_LEGACY_CTRL, 8'h00);
    wr(IDX_MODE, 8'h77);
    wr(IDX_CLK_SEL, 8'h03);
    wr(IDX_A_HIGH, 8'hff);
    wr(IDX_C_LOW, 8'h00);
    wr(IDX_C_HIGH, 8'hff);
    wr(IDX_C_CTRL, 8'h0d);
    wr(IDX_LEGACY_CTRL, 8'h40);
    repeat (60) @(posedge sys_clk);
    rd(IDX_LEGACY_CTRL, 8'hc0);
    rd(IDX_C_CTRL, 8'h8d);
    chk(32'(timer_c_irq), 32'h1);
    stop_test();
  end
endmodule

// ==== pin_partner.sv ====
// Purpose: outside pins feeding the timer unit
// Assumes: pins change right after a system clock edge
// Notes: oscillator runs free, unrelated in phase to the system clock
`timescale 1ns/1ps
module pin_partner (
  input wire logic sys_clk,
  output logic timer_a_count_pin,
  output logic timer_b_count_pin,
  output logic timer_a_gate_input,
  output logic timer_b_gate_input,
  output logic ext_osc_clk
);
  initial begin
    timer_a_count_pin = 1;
    timer_b_count_pin = 1;
    timer_a_gate_input = 0;
    timer_b_gate_input = 0;
    ext_osc_clk = 0;
  end
  always #7.3 ext_osc_clk = ~ext_osc_clk;
  // phases of at least 3 cycles, so the synchroniser never drops an edge
  task automatic pulse(input bit on_b, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      if (on_b)
        timer_b_count_pin <= 0;
      else
        timer_a_count_pin <= 0;
      repeat (3) @(posedge sys_clk);
      timer_a_count_pin <= 1;
      timer_b_count_pin <= 1;
      repeat (3) @(posedge sys_clk);
    end
  endtask
  task automatic gate(input logic a, input logic b);
    @(posedge sys_clk);
    timer_a_gate_input <= a;
    timer_b_gate_input <= b;
  endtask
endmodule

// ==== timer_checker.sv ====
// Purpose: bus and interrupt checks on the timer unit ports
// Assumes: one clock domain, async active high reset
// Notes: bound onto every instance of the timer unit
`timescale 1ns/1ps
module timer_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [timer_pkg::AXI_DW-1:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic timer_c_irq
);
  import timer_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read response dropped");
  AST_R_LAT: assert property (arvalid && arready && ce |=> rvalid)
    else $error("read answer late");
  AST_R_UPPER: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  AST_ERR_ZERO: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == '0)
    else $error("error read carries data");
  AST_B_BUSY: assert property (bvalid |-> !awready && !wready)
    else $error("write taken during response");
  AST_R_BUSY: assert property (rvalid |-> !arready)
    else $error("read taken during response");
  // flags only fall by a software write, so without bus writes the request holds
  AST_IRQ_KEEP: assert property (timer_c_irq && awready && wready && !awvalid && !wvalid |=>
    timer_c_irq) else $error("interrupt request fell by itself");
endmodule
bind legacy_reload_timers timer_checker timer_checker_i (.sys_clk, .rst, .ce, .awvalid,
  .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rresp,
  .rvalid, .rready, .timer_c_irq);

// ==== timer_pkg.sv ====
// Purpose: shared constants and register layouts of the timer unit
// Assumes: 8-bit registers, each on one aligned 32-bit bus word
// Notes: byte address of a register is four times its index
package timer_pkg;

  localparam int AXI_AW = 12;
  localparam int AXI_DW = 32;
  localparam int IDX_W = 8;

  // register indices; byte address = index * 4
  localparam logic [7:0] IDX_LEGACY_CTRL = 8'h88;
  localparam logic [7:0] IDX_MODE = 8'h89;
  localparam logic [7:0] IDX_A_LOW = 8'h8a;
  localparam logic [7:0] IDX_B_LOW = 8'h8b;
  localparam logic [7:0] IDX_A_HIGH = 8'h8c;
  localparam logic [7:0] IDX_B_HIGH = 8'h8d;
  localparam logic [7:0] IDX_CLK_SEL = 8'h8e;
  localparam logic [7:0] IDX_C_CTRL = 8'hc8;
  localparam logic [7:0] IDX_C_RELOAD_LOW = 8'hca;
  localparam logic [7:0] IDX_C_RELOAD_HIGH = 8'hcb;
  localparam logic [7:0] IDX_C_LOW = 8'hcc;
  localparam logic [7:0] IDX_C_HIGH = 8'hcd;
  localparam logic [7:0] IDX_MISC = 8'he4;
  localparam int IDX_LSB = 2;

  localparam logic [7:0] REG_RST = 8'h00;

  // timebase divide counts in system clock cycles; EXT_DIV_LAST counts oscillator edges
  localparam logic [5:0] DIV12 = 6'd12;
  localparam logic [5:0] DIV4 = 6'd4;
  localparam logic [5:0] DIV48 = 6'd48;
  localparam logic [2:0] EXT_DIV_LAST = 3'd7;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    MODE_13 = 2'b00,
    MODE_16 = 2'b01,
    MODE_RELOAD8 = 2'b10,
    MODE_SPLIT = 2'b11
  } legacy_mode_t;

  typedef enum logic [1:0] {
    PS_DIV12 = 2'b00,
    PS_DIV4 = 2'b01,
    PS_DIV48 = 2'b10,
    PS_EXT8 = 2'b11
  } prescale_t;

  typedef struct packed {
    logic timer_b_gate_enable;
    logic timer_b_counter_select;
    legacy_mode_t timer_b_mode_field;
    logic timer_a_gate_enable;
    logic timer_a_counter_select;
    legacy_mode_t timer_a_mode_field;
  } mode_reg_t;

  typedef struct packed {
    logic timer_d_high_clock_select;
    logic timer_d_low_clock_select;
    logic timer_c_high_clock_select;
    logic timer_c_low_clock_select;
    logic timer_b_clock_select;
    logic timer_a_clock_select;
    prescale_t shared_prescale_field;
  } clk_sel_t;

  typedef struct packed {
    logic timer_b_overflow_flag;
    logic timer_b_run;
    logic timer_a_overflow_flag;
    logic timer_a_run;
    logic [3:0] unused;
  } legacy_ctrl_t;

  typedef struct packed {
    logic timer_c_high_overflow_flag;
    logic timer_c_low_overflow_flag;
    logic timer_c_low_irq_enable;
    logic unused_hi;
    logic timer_c_split_mode;
    logic timer_c_run;
    logic unused_lo;
    logic timer_c_external_select;
  } c_ctrl_t;

  typedef struct packed {
    logic [4:0] unused;
    logic timer_c_irq_enable;
    logic gate_b_polarity;
    logic gate_a_polarity;
  } misc_t;

  // synchronised pin group
  typedef struct packed {
    logic ext_osc;
    logic count_b;
    logic count_a;
    logic gate_b;
    logic gate_a;
  } pins_t;

endpackage
